// ===== verilog/spsc_pkg.sv
// constants, encodings and decode values for the strap configuration block
// assumes every strap and link pin is sampled on clk_i after a two-flop synchroniser
package spsc_pkg;
   // clock of the sampling logic
   localparam int CLK_PERIOD_NS = 4;
   // reference treated as stopped (grounded) after this long without an edge
   localparam int REF_IDLE_NS = 16000;
   localparam logic [11:0] REF_IDLE_CYC = 12'(REF_IDLE_NS / CLK_PERIOD_NS);
   // positions of the sampled pins inside the synchroniser vector
   localparam int PIN_DIR = 0;
   localparam int PIN_TERM = 1;
   localparam int PIN_RS0 = 2;
   localparam int PIN_RS1 = 3;
   localparam int PIN_MS0 = 4;
   localparam int PIN_MS1 = 5;
   localparam int PIN_PW0 = 6;
   localparam int PIN_PW1 = 7;
   localparam int PIN_REF = 8;
   localparam int PIN_STB = 9;
   localparam int PIN_SCK = 10;
   localparam int PIN_SDI = 11;
   localparam int PIN_COUNT = 12;
   // reset value of the synchroniser: both range straps low means powered down
   localparam logic [11:0] SYNC_RST = 12'h000;
   // word width of the parallel side
   localparam int WORD_W = 12;
   // reference limits in kHz, normal and spread spectrum
   localparam logic [15:0] REF_SLOW_KHZ = 16'h36B0;     // 14000
   localparam logic [15:0] REF_MED_KHZ = 16'h6D60;      // 28000
   localparam logic [15:0] REF_FAST_KHZ = 16'h9C40;     // 40000
   localparam logic [15:0] REF_SLOW_SS_KHZ = 16'h33F4;  // 13300
   localparam logic [15:0] REF_MED_SS_KHZ = 16'h684C;   // 26700
   localparam logic [15:0] REF_FAST_SS_KHZ = 16'h9538;  // 38200
   // pll multiplier in thousandths
   localparam logic [11:0] PLL_X1_MILLI = 12'h3E8;      // 1000
   localparam logic [11:0] PLL_SS_MILLI = 12'h3BA;      // 954
   localparam logic [11:0] PLL_X2_MILLI = 12'h7D0;      // 2000
   localparam logic [11:0] PLL_X3_MILLI = 12'hBB8;      // 3000
   // whole multipliers for low-time arithmetic and strobe division
   localparam logic [1:0] MULT_1 = 2'h1;
   localparam logic [1:0] MULT_2 = 2'h2;
   localparam logic [1:0] MULT_3 = 2'h3;
   // pulse width multipliers
   localparam logic [4:0] PW_7 = 5'h07;
   localparam logic [4:0] PW_13 = 5'h0D;
   localparam logic [4:0] PW_17 = 5'h11;
   // low-time divisor
   localparam logic [18:0] LOW_DIV = 19'h0000E;        // 14
   // frequency range classes, also the edge rate classes of the deserializer
   typedef enum logic [1:0] {RNG_OFF, RNG_SLOW, RNG_MED, RNG_FAST} spsc_range_e;
endpackage : spsc_pkg

// ===== verilog/spsc_fifo_if.sv
// handshake bundle between the deserializer front end and its word fifo
// assumes one clock; valid and ready follow the usual stream rules
`timescale 1ns/1ps
interface spsc_fifo_if #(parameter int W = 12);
   logic push_valid;  // word offered
   logic push_ready;  // room for it
   logic [W-1:0] push_data;
   logic pop_valid;   // word available
   logic pop_ready;   // consumer takes it
   logic [W-1:0] pop_data;
   modport fifo (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
   modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface : spsc_fifo_if

// ===== verilog/spsc_fifo.sv
// small synchronous word fifo with registered read data
// assumes the flush input is a synchronous clear from the same clock
`timescale 1ns/1ps
module spsc_fifo #(
   parameter int W = 12,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic flush_i,
   // stream ports
   spsc_fifo_if.fifo f
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   logic [W-1:0] mem_reg [DEPTH];   // storage
   logic [W-1:0] out_reg;           // registered head word
   logic out_vld_reg, out_vld_next;
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0] cnt_reg, cnt_next;  // words in storage, head excluded
   logic do_push, do_load;
   // full counts storage only, so the head register adds one word of slack
   assign f.push_ready = (cnt_reg != DEPTH_C);
   assign f.pop_valid = out_vld_reg;
   assign f.pop_data = out_reg;
   assign do_push = f.push_valid && f.push_ready;
   assign do_load = (cnt_reg != '0) && (!out_vld_reg || f.pop_ready);
   // pointer and count update
   always_comb begin
      wr_next = do_push ? AW'(wr_reg + 1'b1) : wr_reg;
      rd_next = do_load ? AW'(rd_reg + 1'b1) : rd_reg;
      cnt_next = cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_load);
      if (do_load) begin
         out_vld_next = 1'b1;
      end else if (f.pop_ready) begin
         out_vld_next = 1'b0;
      end else begin
         out_vld_next = out_vld_reg;
      end
      if (flush_i) begin
         wr_next = '0;
         rd_next = '0;
         cnt_next = '0;
         out_vld_next = 1'b0;
      end
   end
   // control registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         out_vld_reg <= 1'b0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
         out_vld_reg <= out_vld_next;
      end
   end
   // storage and head word carry no reset, they are qualified by the valid bits
   always_ff @(posedge clk_i) begin
      if (do_push) begin
         mem_reg[wr_reg] <= f.push_data;
      end
      if (do_load) begin
         out_reg <= mem_reg[rd_reg];
      end
   end
endmodule : spsc_fifo

// ===== verilog/spsc_top.sv
// strap decoding, direction control and deserializer word output
// assumes straps are static pins, sampled here through two flip-flops
`timescale 1ns/1ps
module spsc_top #(
   parameter int FIFO_DEPTH = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // strap pins
   input wire logic direction_select_i,
   input wire logic termination_select_i,
   input wire logic range_select_0_i,
   input wire logic range_select_1_i,
   input wire logic multiplier_select_0_i,
   input wire logic multiplier_select_1_i,
   input wire logic pulse_width_select_0_i,
   input wire logic pulse_width_select_1_i,
   // clock and link pins
   input wire logic reference_clock_in_i,
   input wire logic strobe_in_i,
   input wire logic serial_clock_in_i,
   input wire logic serial_data_in_i,
   // direction and status
   output logic direction_inverse_out_o,
   output logic serializer_mode_o,
   output logic powered_down_o,
   output logic internal_term_en_o,
   output logic pass_through_o,
   output logic overflow_o,
   // serializer decode
   output logic [1:0] range_class_o,
   output logic [11:0] pll_mult_milli_o,
   output logic [15:0] ref_max_khz_o,
   output logic [15:0] strobe_max_khz_o,
   // deserializer decode
   output logic [1:0] assumed_pll_mult_o,
   output logic [4:0] pulse_width_mult_o,
   output logic word_clock_inverted_o,
   output logic [14:0] low_cycles_o,
   // parallel side, three-signal pins
   output logic [11:0] parallel_data_o,
   output logic parallel_data_oe_o,
   output logic parallel_word_clock_o,
   output logic parallel_word_clock_oe_o,
   output logic serial_clock_out_o,
   output logic serial_clock_out_oe_o
);
   typedef enum logic [1:0] {WC_IDLE, WC_LOW, WC_HIGH} spsc_wc_e;
   // pin synchroniser: stage a is read by stage b only
   logic [11:0] sync_a_reg, sync_b_reg, sync_c_reg;
   logic [11:0] pins;
   logic dir, pd, ms0, ms1, ref_rise, sck_rise;
   spsc_pkg::spsc_range_e rng;
   // decode registers
   logic dir_inv_reg, dir_inv_next, ser_reg, ser_next, pd_reg, pd_next;
   logic term_reg, term_next, inv_reg, inv_next;
   logic [1:0] rng_reg, rng_next, apll_reg, apll_next, div_sel;
   logic [11:0] milli_reg, milli_next;
   logic [15:0] refmax_reg, refmax_next, stbmax_reg, stbmax_next;
   logic [4:0] pw_reg, pw_next;
   // reference period measurement
   logic [11:0] ref_cnt_reg, ref_cnt_next, period_reg, period_next;
   logic idle_reg, idle_next;
   logic [18:0] low_prod;
   logic [14:0] low_reg, low_next;
   // serial shifter and word hand-off
   logic [11:0] shift_reg, shift_next, pend_reg, pend_next;
   logic [3:0] bits_reg, bits_next;
   logic pend_vld_reg, pend_vld_next, ovf_reg, ovf_next;
   // word clock generator
   spsc_wc_e wc_reg, wc_next;
   logic [14:0] wc_cnt_reg, wc_cnt_next;
   logic [11:0] dout_reg, dout_next;
   logic wcout_reg, wcout_next, wcoe_reg, wcoe_next, doe_reg, doe_next;
   logic sco_reg, sco_next, scoe_reg, scoe_next;
   spsc_fifo_if #(.W(spsc_pkg::WORD_W)) fq ();

   assign pins = {serial_data_in_i, serial_clock_in_i, strobe_in_i, reference_clock_in_i,
                  pulse_width_select_1_i, pulse_width_select_0_i, multiplier_select_1_i,
                  multiplier_select_0_i, range_select_1_i, range_select_0_i,
                  termination_select_i, direction_select_i};
   // two flip-flops before any logic, third stage only for edge detection
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_a_reg <= spsc_pkg::SYNC_RST;
         sync_b_reg <= spsc_pkg::SYNC_RST;
         sync_c_reg <= spsc_pkg::SYNC_RST;
      end else begin
         sync_a_reg <= pins;
         sync_b_reg <= sync_a_reg;
         sync_c_reg <= sync_b_reg;
      end
   end
   assign dir = sync_b_reg[spsc_pkg::PIN_DIR];
   assign ms0 = sync_b_reg[spsc_pkg::PIN_MS0];
   assign ms1 = sync_b_reg[spsc_pkg::PIN_MS1];
   // both range straps low reset the reference measurement, shifter, fifo and word clock below
   assign pd = !sync_b_reg[spsc_pkg::PIN_RS0] && !sync_b_reg[spsc_pkg::PIN_RS1];
   assign ref_rise = sync_b_reg[spsc_pkg::PIN_REF] && !sync_c_reg[spsc_pkg::PIN_REF];
   assign sck_rise = sync_b_reg[spsc_pkg::PIN_SCK] && !sync_c_reg[spsc_pkg::PIN_SCK];
   assign div_sel = {ms1, ms0};

   // strap decode, recomputed every cycle since the straps are static
   always_comb begin
      unique case ({sync_b_reg[spsc_pkg::PIN_RS0], sync_b_reg[spsc_pkg::PIN_RS1]})
         2'b01: rng = spsc_pkg::RNG_SLOW;
         2'b11: rng = spsc_pkg::RNG_MED;
         2'b10: rng = spsc_pkg::RNG_FAST;
         default: rng = spsc_pkg::RNG_OFF;
      endcase
      ser_next = dir;
      pd_next = pd;
      // inversion holds in power-down as well: 0 as serializer, 1 as deserializer
      dir_inv_next = !dir;
      term_next = !dir && !pd && !sync_b_reg[spsc_pkg::PIN_TERM];
      rng_next = rng;
      // multiplier straps, first bit is select 1
      unique case (div_sel)
         2'b01: milli_next = spsc_pkg::PLL_X1_MILLI;
         2'b00: milli_next = spsc_pkg::PLL_SS_MILLI;
         2'b10: milli_next = spsc_pkg::PLL_X2_MILLI;
         default: milli_next = spsc_pkg::PLL_X3_MILLI;
      endcase
      unique case (rng)
         spsc_pkg::RNG_SLOW: refmax_next = (div_sel == 2'b00) ? spsc_pkg::REF_SLOW_SS_KHZ
                                                              : spsc_pkg::REF_SLOW_KHZ;
         spsc_pkg::RNG_MED: refmax_next = (div_sel == 2'b00) ? spsc_pkg::REF_MED_SS_KHZ
                                                             : spsc_pkg::REF_MED_KHZ;
         spsc_pkg::RNG_FAST: refmax_next = (div_sel == 2'b00) ? spsc_pkg::REF_FAST_SS_KHZ
                                                              : spsc_pkg::REF_FAST_KHZ;
         default: refmax_next = 16'h0000;
      endcase
      // strobe may run at the reference divided by the whole multiplier
      unique case (div_sel)
         2'b10: stbmax_next = refmax_next / 16'(spsc_pkg::MULT_2);
         2'b11: stbmax_next = refmax_next / 16'(spsc_pkg::MULT_3);
         default: stbmax_next = refmax_next;
      endcase
      // deserializer: the range picks the serializer multiplier it pairs with
      unique case (rng)
         spsc_pkg::RNG_SLOW: apll_next = spsc_pkg::MULT_2;
         spsc_pkg::RNG_MED: apll_next = spsc_pkg::MULT_3;
         default: apll_next = spsc_pkg::MULT_1;
      endcase
      unique case ({sync_b_reg[spsc_pkg::PIN_PW0], sync_b_reg[spsc_pkg::PIN_PW1]})
         2'b01: pw_next = spsc_pkg::PW_13;
         2'b11: pw_next = spsc_pkg::PW_17;
         default: pw_next = spsc_pkg::PW_7;
      endcase
      inv_next = sync_b_reg[spsc_pkg::PIN_PW0] && !sync_b_reg[spsc_pkg::PIN_PW1];
      if (pd) begin
         milli_next = 12'h000;
         stbmax_next = 16'h0000;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ser_reg <= 1'b0;
         pd_reg <= 1'b1;
         dir_inv_reg <= 1'b1;
         term_reg <= 1'b0;
         rng_reg <= 2'h0;
         milli_reg <= 12'h000;
         refmax_reg <= 16'h0000;
         stbmax_reg <= 16'h0000;
         apll_reg <= 2'h1;
         pw_reg <= 5'h07;
         inv_reg <= 1'b0;
      end else begin
         ser_reg <= ser_next;
         pd_reg <= pd_next;
         dir_inv_reg <= dir_inv_next;
         term_reg <= term_next;
         rng_reg <= rng_next;
         milli_reg <= milli_next;
         refmax_reg <= refmax_next;
         stbmax_reg <= stbmax_next;
         apll_reg <= apll_next;
         pw_reg <= pw_next;
         inv_reg <= inv_next;
      end
   end

   // reference period in clk cycles, and the low time derived from it
   assign low_prod = 19'(apll_reg) * 19'(pw_reg) * 19'(period_reg);
   always_comb begin
      ref_cnt_next = ref_rise ? 12'h000 : ref_cnt_reg;
      period_next = period_reg;
      idle_next = idle_reg;
      if (ref_rise) begin
         period_next = 12'(ref_cnt_reg + 1'b1);
         idle_next = 1'b0;
      end else if (ref_cnt_reg >= spsc_pkg::REF_IDLE_CYC) begin
         // a grounded reference selects clock pass-through
         idle_next = 1'b1;
      end else begin
         ref_cnt_next = 12'(ref_cnt_reg + 1'b1);
      end
      low_next = 15'(low_prod / spsc_pkg::LOW_DIV);
      if (low_next == 15'h0000) begin
         low_next = 15'h0001;
      end
      if (pd) begin
         ref_cnt_next = 12'h000;
         period_next = 12'h000;
         idle_next = 1'b0;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_cnt_reg <= 12'h000;
         period_reg <= 12'h000;
         idle_reg <= 1'b0;
         low_reg <= 15'h0001;
      end else begin
         ref_cnt_reg <= ref_cnt_next;
         period_reg <= period_next;
         idle_reg <= idle_next;
         low_reg <= low_next;
      end
   end

   // serial shifter: a finished word waits in pend while the fifo is full
   assign fq.push_valid = pend_vld_reg;
   assign fq.push_data = pend_reg;
   always_comb begin
      shift_next = shift_reg;
      bits_next = bits_reg;
      pend_next = pend_reg;
      pend_vld_next = pend_vld_reg && !fq.push_ready;
      ovf_next = ovf_reg;
      if (!ser_reg && sck_rise) begin
         shift_next = {shift_reg[10:0], sync_b_reg[spsc_pkg::PIN_SDI]};
         bits_next = 4'(bits_reg + 1'b1);
         if (bits_reg == 4'hB) begin
            bits_next = 4'h0;
            if (pend_vld_next) begin
               ovf_next = 1'b1; // word lost, held word wins
            end else begin
               pend_next = {shift_reg[10:0], sync_b_reg[spsc_pkg::PIN_SDI]};
               pend_vld_next = 1'b1;
            end
         end
      end
      if (pd) begin
         bits_next = 4'h0;
         pend_vld_next = 1'b0;
         ovf_next = 1'b0;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_reg <= 12'h000;
         bits_reg <= 4'h0;
         pend_reg <= 12'h000;
         pend_vld_reg <= 1'b0;
         ovf_reg <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         bits_reg <= bits_next;
         pend_reg <= pend_next;
         pend_vld_reg <= pend_vld_next;
         ovf_reg <= ovf_next;
      end
   end

   spsc_fifo #(.W(spsc_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .flush_i(pd),
      .f(fq)
   );

   // word clock: new word at the falling edge, held low for the low time
   assign fq.pop_ready = (wc_reg == WC_IDLE) && !ser_reg && !pd;
   always_comb begin
      wc_next = wc_reg;
      wc_cnt_next = wc_cnt_reg;
      dout_next = dout_reg;
      unique case (wc_reg)
         WC_IDLE: begin
            if (fq.pop_ready && fq.pop_valid) begin
               dout_next = fq.pop_data;
               wc_cnt_next = low_reg;
               wc_next = WC_LOW;
            end
         end
         WC_LOW: begin
            wc_cnt_next = 15'(wc_cnt_reg - 1'b1);
            if (wc_cnt_reg == 15'h0001) begin
               wc_next = WC_HIGH;
            end
         end
         WC_HIGH: wc_next = WC_IDLE;
      endcase
      // pin drive: deserializer floats in power-down, serializer holds high
      doe_next = !ser_reg && !pd;
      wcoe_next = ser_reg || !pd;
      if (ser_reg) begin
         // serializer forwards the incoming master clock onto the word clock
         wcout_next = pd || sync_b_reg[spsc_pkg::PIN_SCK];
      end else begin
         wcout_next = (wc_next != WC_LOW) ^ inv_next;
      end
      // deserializer with grounded reference forwards the strobe clock
      scoe_next = !ser_reg && !pd && idle_reg;
      sco_next = scoe_next && sync_b_reg[spsc_pkg::PIN_STB];
      if (pd) begin
         wc_next = WC_IDLE;
         wc_cnt_next = 15'h0000;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wc_reg <= WC_IDLE;
         wc_cnt_reg <= 15'h0000;
         dout_reg <= 12'h000;
         doe_reg <= 1'b0;
         wcout_reg <= 1'b0;
         wcoe_reg <= 1'b0;
         sco_reg <= 1'b0;
         scoe_reg <= 1'b0;
      end else begin
         wc_reg <= wc_next;
         wc_cnt_reg <= wc_cnt_next;
         dout_reg <= dout_next;
         doe_reg <= doe_next;
         wcout_reg <= wcout_next;
         wcoe_reg <= wcoe_next;
         sco_reg <= sco_next;
         scoe_reg <= scoe_next;
      end
   end

   assign direction_inverse_out_o = dir_inv_reg;
   assign serializer_mode_o = ser_reg;
   assign powered_down_o = pd_reg;
   assign internal_term_en_o = term_reg;
   assign pass_through_o = scoe_reg;
   assign overflow_o = ovf_reg;
   assign range_class_o = rng_reg;
   assign pll_mult_milli_o = milli_reg;
   assign ref_max_khz_o = refmax_reg;
   assign strobe_max_khz_o = stbmax_reg;
   assign assumed_pll_mult_o = apll_reg;
   assign pulse_width_mult_o = pw_reg;
   assign word_clock_inverted_o = inv_reg;
   assign low_cycles_o = low_reg;
   assign parallel_data_o = dout_reg;
   assign parallel_data_oe_o = doe_reg;
   assign parallel_word_clock_o = wcout_reg;
   assign parallel_word_clock_oe_o = wcoe_reg;
   assign serial_clock_out_o = sco_reg;
   assign serial_clock_out_oe_o = scoe_reg;

   // checks on the decoded outputs and the word path
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   mode_follow_a: assert property (##1 serializer_mode_o == $past(dir))
      else $error("mode does not follow direction strap");
   term_sel_a: assert property (internal_term_en_o |-> !serializer_mode_o && !powered_down_o)
      else $error("internal termination outside deserializer");
   dir_inv_a: assert property (direction_inverse_out_o == !$past(dir))
      else $error("direction inverse wrong");
   range_fast_a: assert property (range_class_o == 2'h3 && pll_mult_milli_o == 12'h3E8
      |-> ref_max_khz_o == 16'h9C40) else $error("fast limit wrong");
   strobe_div_a: assert property (pll_mult_milli_o == 12'hBB8
      |-> strobe_max_khz_o == ref_max_khz_o / 16'h0003) else $error("strobe limit wrong");
   spread_lim_a: assert property (pll_mult_milli_o == 12'h3BA && range_class_o == 2'h1
      |-> ref_max_khz_o == 16'h33F4) else $error("spread limit wrong");
   pd_quiet_a: assert property (pd [*2] |=> !parallel_data_oe_o && wc_reg == WC_IDLE
      && !overflow_o) else $error("power-down not quiet");
   pw_inv_a: assert property (word_clock_inverted_o |-> pulse_width_mult_o == 5'h07)
      else $error("inversion with wrong pulse width");
   edge_mult_a: assert property (range_class_o == 2'h2 |-> assumed_pll_mult_o == 2'h3)
      else $error("medium multiplier wrong");
   low_len_a: assert property (disable iff (rst_i || pd)
      wc_reg == WC_IDLE && wc_next == WC_LOW && low_reg == 15'h0008
      |=> (wc_reg == WC_LOW) [*8] ##1 wc_reg == WC_HIGH) else $error("low time length wrong");
   word_out_a: assert property (fq.pop_ready && fq.pop_valid |=> parallel_data_o ==
      $past(fq.pop_data)) else $error("word not presented");
   pass_fwd_a: assert property (serial_clock_out_oe_o |-> !serializer_mode_o)
      else $error("pass-through in serializer");
   word_cov_c: cover property (wc_reg == WC_LOW ##1 wc_reg == WC_HIGH);
   ovf_cov_c: cover property ($rose(overflow_o));
   pass_cov_c: cover property ($rose(serial_clock_out_oe_o));
endmodule : spsc_top

// ===== verif/tb_spsc_top.sv
// self-checking bench for the strap decoder and the deserializer word output
// assumes the package, fifo and top of verilog/ are compiled first
`timescale 1ns/1ps
module tb_spsc_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] st = 8'h00;  // straps: pw1,pw0,ms1,ms0,rs1,rs0,term,dir
   logic ref_r = 1'b0;  // reference, also fed to the strobe pin while it runs
   logic ref_on = 1'b1;  // low grounds the reference, the strobe then runs alone
   logic sck_r = 1'b0;
   logic sdi_r = 1'b0;
   logic [2:0] ref_cnt = 3'h0;  // fixed 16-clock reference keeps low time predictable
   logic [15:0] lf = 16'h000F;  // random source
   logic dinv, ser, pd, iterm, winv, wclk;
   logic doe, wcoe, ovf, pt, sco, scoe, prev;
   logic [1:0] rc, ap;
   logic [4:0] pw;
   logic [11:0] pm, pdata;
   logic [14:0] low;
   logic [15:0] rm, sm;
   int w;
   int failures = 0;
   int total_checks = 0;
   always #2 clk_i = ~clk_i;
   // free-running reference divider
   always @(posedge clk_i) begin
      ref_cnt <= ref_cnt + 3'h1;
      if (ref_cnt == 3'h7) begin
         ref_r <= ~ref_r & ref_on;
      end
   end
   spsc_top spsc_top_i (
      .clk_i(clk_i), .rst_i(rst_i),
      .direction_select_i(st[0]), .termination_select_i(st[1]),
      .range_select_0_i(st[2]), .range_select_1_i(st[3]),
      .multiplier_select_0_i(st[4]), .multiplier_select_1_i(st[5]),
      .pulse_width_select_0_i(st[6]), .pulse_width_select_1_i(st[7]),
      .reference_clock_in_i(ref_r), .strobe_in_i(ref_on ? ref_r : ref_cnt[2]),
      .serial_clock_in_i(sck_r), .serial_data_in_i(sdi_r),
      .direction_inverse_out_o(dinv), .serializer_mode_o(ser), .powered_down_o(pd),
      .internal_term_en_o(iterm), .pass_through_o(pt), .overflow_o(ovf),
      .range_class_o(rc), .pll_mult_milli_o(pm), .ref_max_khz_o(rm), .strobe_max_khz_o(sm),
      .assumed_pll_mult_o(ap), .pulse_width_mult_o(pw), .word_clock_inverted_o(winv),
      .low_cycles_o(low), .parallel_data_o(pdata), .parallel_data_oe_o(doe),
      .parallel_word_clock_o(wclk), .parallel_word_clock_oe_o(wcoe),
      .serial_clock_out_o(sco), .serial_clock_out_oe_o(scoe));
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // expected decode of one strap set, packed as in the compare below
   function automatic logic [57:0] dec(input logic [7:0] s);
      logic [1:0] c;
      logic [11:0] m;
      logic [15:0] r;
      logic [15:0] d;
      c = s[2] ? (s[3] ? 2'h2 : 2'h3) : {1'b0, s[3]};
      m = s[4] ? (s[5] ? 12'hBB8 : 12'h3E8) : (s[5] ? 12'h7D0 : 12'h3BA);
      d = s[5] ? (s[4] ? 16'h0003 : 16'h0002) : 16'h0001;
      case (c)
         2'h1: r = (m == 12'h3BA) ? 16'h33F4 : 16'h36B0;
         2'h2: r = (m == 12'h3BA) ? 16'h684C : 16'h6D60;
         2'h3: r = (m == 12'h3BA) ? 16'h9538 : 16'h9C40;
         default: r = 16'h0000;
      endcase
      return {s[0], ~s[0], c == 2'h0, ~s[0] & ~s[1] & (c != 2'h0), c,
         (c == 2'h0) ? 12'h000 : m, r, r / d,
         (c == 2'h1) ? 2'h2 : (c == 2'h2) ? 2'h3 : 2'h1,
         s[7] ? (s[6] ? 5'h11 : 5'h0D) : 5'h07, s[6] & ~s[7]};
   endfunction
   // expected pin drive with an idle link: enables, word clock level, no pass-through
   function automatic logic [5:0] pin_exp(input logic [7:0] s);
      return {~s[0] & (s[2] | s[3]), s[0] | s[2] | s[3],
         s[0] ? ~(s[2] | s[3]) : ~(s[6] & ~s[7]), 3'h0};
   endfunction
   task automatic chk(input logic [57:0] seen, input logic [57:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      // every range and multiplier code in serializer direction first, then random
      for (int i = 0; i < 48; i++) begin
         lf = nxt(lf);
         @(posedge clk_i);
         st <= (i < 16) ? {lf[7:6], i[3:0], lf[1], 1'b1} : lf[7:0];
         repeat (4) @(posedge clk_i);
         #1;
         chk({ser, dinv, pd, iterm, rc, pm, rm, sm, ap, pw, winv}, dec(st), "decode");
         chk(58'({doe, wcoe, wclk, pt, sco, scoe}), 58'(pin_exp(st)), "pins");
      end
      $display("decode test done");
      // deserializer, fast range, pulse width 7: low time 16*1*7/14 clocks
      @(posedge clk_i);
      st <= 8'h04;
      repeat (60) @(posedge clk_i);
      #1;
      chk(58'(low), 58'h8, "low time");
      lf = nxt(lf);
      for (int b = 11; b >= 0; b--) begin
         @(posedge clk_i);
         sdi_r <= lf[b];
         sck_r <= 1'b0;
         repeat (3) @(posedge clk_i);
         sck_r <= 1'b1;
         repeat (2) @(posedge clk_i);
      end
      for (w = 0; w < 100 && wclk !== 1'b0; w++) begin
         @(posedge clk_i);
         #1;
      end
      chk(58'(pdata), 58'(lf[11:0]), "word");
      for (w = 0; w < 50 && wclk === 1'b0; w++) begin
         @(posedge clk_i);
         #1;
      end
      chk(58'(w), 58'h8, "word clock low");
      chk(58'(ovf), 58'h0, "overflow");
      $display("word test done");
      // ground the reference: after the idle span the strobe clock is forwarded
      @(posedge clk_i);
      ref_on <= 1'b0;
      repeat (4100) @(posedge clk_i);
      #1;
      chk(58'({pt, scoe}), 58'h3, "pass-through");
      prev = sco;
      w = 0;
      // strobe period is 8 clocks, so 32 samples hold exactly 4 rises
      repeat (32) begin
         @(posedge clk_i);
         #1;
         if (sco && !prev) begin
            w++;
         end
         prev = sco;
      end
      chk(58'(w), 58'h4, "forwarded strobe");
      $display("pass-through test done");
      end_of_test();
   end
   // the run needs about 4600 clocks; this cuts a hang short
   initial begin
      #40000;
      failures++;
      end_of_test();
   end
endmodule // tb_spsc_top
